// File: rtl/smsp_spi.sv
`timescale 1ns/1ps
module smsp_spi #(
  parameter int unsigned DIV4  = 4,
  parameter int unsigned DIV16 = 16,
  parameter int unsigned DIVX  = 10
) (
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [smsp_pkg::AW-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   sub_clk,
  input  wire logic                   timer_period_match,
  input  wire logic                   sck_in,
  input  wire logic                   sdi,
  input  wire logic                   slave_select_n_in,
  output smsp_pkg::smsp_pins_s        pins,
  output logic                        irq
);

  logic [7:0]                 serial_mode_control;
  logic [7:0]                 serial_config_flags;
  logic [7:0]                 serial_shift_data;
  logic [smsp_pkg::IRQ_W-1:0] irq_status;
  logic [smsp_pkg::IRQ_W-1:0] irq_enable;
  smsp_pkg::smsp_state_e      state;
  logic [7:0]                 div_cnt;
  logic [7:0]                 half_m1;
  logic [3:0]                 edge_cnt;
  logic                       sub_prev;
  logic                       sck_prev;
  logic                       rx_bit;
  logic                       tick;
  logic                       lead_ev;
  logic                       trail_ev;
  logic                       done;
  logic                       busy;
  logic                       sel;
  logic                       wr_acc;
  logic                       wr_data;
  logic                       coll;
  logic                       enabled;
  logic                       idle_lvl;
  logic                       msb_first;
  logic                       is_master;
  logic [7:0]                 next_shift;
  smsp_pkg::smsp_mode_e       mode;

  // Decoded controls
  assign mode      = smsp_pkg::smsp_mode_e'(serial_mode_control[7:smsp_pkg::MC_MODE_LSB]);
  assign enabled   = serial_mode_control[smsp_pkg::MC_EN];
  assign idle_lvl  = ~serial_config_flags[smsp_pkg::CF_POL];  // [RL13]
  assign msb_first = serial_config_flags[smsp_pkg::CF_ORDER];  // [RL14]
  assign is_master = (mode == smsp_pkg::MODE_DIV4) || (mode == smsp_pkg::MODE_DIV16) ||
                     (mode == smsp_pkg::MODE_DIVX) || (mode == smsp_pkg::MODE_SUB) ||
                     (mode == smsp_pkg::MODE_TMR);
  assign sel       = ~serial_config_flags[smsp_pkg::CF_SELECT_PIN_ENABLE] | ~slave_select_n_in;  // [RL6]
  assign busy      = (state == smsp_pkg::ST_MASTER) || (edge_cnt != 4'h0);
  assign wr_acc    = psel & penable & pready & pwrite;
  assign wr_data   = wr_acc && (paddr == smsp_pkg::OFF_DATA);
  assign coll      = wr_data && busy;  // [RL16]

  // Half period of the selected divider
  always_comb
  begin
    case (mode)
      smsp_pkg::MODE_DIV4:  half_m1 = 8'(DIV4 / 2 - 1);  // [RL1]
      smsp_pkg::MODE_DIV16: half_m1 = 8'(DIV16 / 2 - 1);
      default:              half_m1 = 8'(DIVX / 2 - 1);
    endcase
  end

  // Clock edge request for master mode
  always_comb
  begin
    case (mode)
      smsp_pkg::MODE_SUB: tick = sub_clk != sub_prev;  // [RL2]
      smsp_pkg::MODE_TMR: tick = timer_period_match;   // [RL2]
      default:            tick = div_cnt == half_m1;   // [RL1]
    endcase
  end

  // Leading and trailing edges, own or external
  always_comb
  begin
    if (state == smsp_pkg::ST_MASTER)
    begin
      lead_ev  = tick & ~edge_cnt[0];  // [RL5]
      trail_ev = tick & edge_cnt[0];
    end
    else if (state == smsp_pkg::ST_SLAVE)
    begin
      lead_ev  = sel && (sck_in != sck_prev) && (sck_in != idle_lvl);  // [RL4]
      trail_ev = sel && (sck_in != sck_prev) && (sck_in == idle_lvl);
    end
    else
    begin
      lead_ev  = 1'b0;
      trail_ev = 1'b0;
    end
  end
  assign done = trail_ev && (edge_cnt == smsp_pkg::LAST_EDGE);

  // Shifted value with sampled or live input
  always_comb
  begin
    if (msb_first)  // [RL11]
      next_shift = {serial_shift_data[6:0], serial_config_flags[smsp_pkg::CF_EDGE] ? rx_bit : sdi};
    else
      next_shift = {serial_config_flags[smsp_pkg::CF_EDGE] ? rx_bit : sdi, serial_shift_data[7:1]};
  end

  // Input edge history
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sub_prev <= 1'b0;
      sck_prev <= 1'b0;
    end
    else
    begin
      sub_prev <= sub_clk;
      sck_prev <= sck_in;
    end
  end

  // Divider counter
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      div_cnt <= 8'h00;
    else if (state != smsp_pkg::ST_MASTER || div_cnt == half_m1)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  // Transfer state
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      state <= smsp_pkg::ST_IDLE;
    else if (!enabled)
      state <= smsp_pkg::ST_IDLE;  // [RL17]
    else if (mode == smsp_pkg::MODE_SLAVE)
      state <= smsp_pkg::ST_SLAVE;
    else if (!is_master)
      state <= smsp_pkg::ST_IDLE;
    else
    begin
      case (state)
        smsp_pkg::ST_MASTER: if (done) state <= smsp_pkg::ST_IDLE;  // [RL18]
        smsp_pkg::ST_IDLE:   if (wr_data) state <= smsp_pkg::ST_MASTER;  // [RL18]
        default:             state <= smsp_pkg::ST_IDLE;
      endcase
    end
  end

  // Edge counter, cleared when the slave is deselected
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      edge_cnt <= 4'h0;
    else if (!enabled || state == smsp_pkg::ST_IDLE || (state == smsp_pkg::ST_SLAVE && !sel))
      edge_cnt <= 4'h0;
    else if (lead_ev || trail_ev)
      edge_cnt <= edge_cnt + 4'h1;
  end

  // Shift data register, full duplex
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      serial_shift_data <= smsp_pkg::DATA_RST;
      rx_bit            <= 1'b0;
    end
    else
    begin
      if (wr_data && !busy)
        serial_shift_data <= pwdata[7:0];  // [RL8]
      else if (trail_ev)
        serial_shift_data <= next_shift;  // [RL7]
      if (lead_ev)
        rx_bit <= sdi;  // [RL12]
    end
  end

  // Mode control register
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      serial_mode_control <= smsp_pkg::MC_RST;  // [RL3]
    else if (wr_acc && paddr == smsp_pkg::OFF_MODE)
      serial_mode_control <= pwdata[7:0] & smsp_pkg::MC_WMASK;  // [RL9]
  end

  // Config flags; hardware set wins over clear
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      serial_config_flags <= smsp_pkg::CF_RST;
    else
    begin
      if (wr_acc && paddr == smsp_pkg::OFF_CFG)
        serial_config_flags <= pwdata[7:0];
      if (done)
        serial_config_flags[smsp_pkg::CF_TRF] <= 1'b1;  // [RL15]
      if (coll)
        serial_config_flags[smsp_pkg::CF_WRITE_COLLISION_FLAG] <= 1'b1;  // [RL16]
    end
  end

  // Interrupt status, enable and output
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_status <= '0;
      irq_enable <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      if (wr_acc && paddr == smsp_pkg::OFF_IRQ_EN)
        irq_enable <= pwdata[smsp_pkg::IRQ_W-1:0];
      irq_status <= (irq_status & ~((wr_acc && paddr == smsp_pkg::OFF_IRQ_CLR) ?
                     pwdata[smsp_pkg::IRQ_W-1:0] : {smsp_pkg::IRQ_W{1'b0}})) |
                    {coll, done};
      irq        <= |(irq_status & irq_enable);  // [RL15]
    end
  end

  // Pin drivers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      pins <= '{sck: 1'b1, sck_oe_n: 1'b1, sdo: 1'b0, sdo_oe_n: 1'b1, ss_n: 1'b1, ss_oe_n: 1'b1};
    else
    begin
      pins.sck_oe_n <= ~(enabled & is_master);  // [RL5] [RL17]
      pins.sdo_oe_n <= ~(enabled & (is_master | ((mode == smsp_pkg::MODE_SLAVE) & sel)));  // [RL17]
      pins.ss_oe_n  <= ~(enabled & is_master & serial_config_flags[smsp_pkg::CF_SELECT_PIN_ENABLE]);  // [RL6]
      pins.ss_n     <= state != smsp_pkg::ST_MASTER;
      if (state == smsp_pkg::ST_MASTER)
      begin
        if (tick)
          pins.sck <= edge_cnt[0] ? idle_lvl : ~idle_lvl;  // [RL13]
      end
      else
        pins.sck <= idle_lvl;
      if (wr_data && !busy)
        pins.sdo <= msb_first ? pwdata[7] : pwdata[0];
      else if (lead_ev && !serial_config_flags[smsp_pkg::CF_EDGE])
        pins.sdo <= msb_first ? serial_shift_data[7] : serial_shift_data[0];  // [RL7]
      else if (trail_ev && serial_config_flags[smsp_pkg::CF_EDGE])
        pins.sdo <= msb_first ? next_shift[7] : next_shift[0];
    end
  end

  // APB slave, no wait states
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable)
      begin
        case (paddr)
          smsp_pkg::OFF_MODE:     prdata[7:0] <= serial_mode_control;
          smsp_pkg::OFF_CFG:      prdata[7:0] <= serial_config_flags;
          smsp_pkg::OFF_DATA:     prdata[7:0] <= serial_shift_data;  // [RL8]
          smsp_pkg::OFF_IRQ_STAT: prdata[smsp_pkg::IRQ_W-1:0] <= irq_status;
          smsp_pkg::OFF_IRQ_EN:   prdata[smsp_pkg::IRQ_W-1:0] <= irq_enable;
          smsp_pkg::OFF_IRQ_CLR:  prdata <= 32'h0000_0000;
          default:                pslverr <= 1'b1;
        endcase
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Disabled block lets go of the lines
  property p_off_float;
    !enabled |=> pins.sck_oe_n && pins.sdo_oe_n && pins.ss_oe_n;
  endproperty
  a_off_float: assert property (p_off_float) else $error("lines driven while disabled"); // [RL17]

  // Divide-by-4 master ticks every other cycle
  property p_div4;
    (state == smsp_pkg::ST_MASTER && mode == smsp_pkg::MODE_DIV4 && tick && !done) |=> !tick ##1 tick;
  endproperty
  a_div4: assert property (p_div4) else $error("divide-by-4 rate wrong"); // [RL1]

  // Last edge ends transfer and sets done flag
  property p_len;
    (state == smsp_pkg::ST_MASTER && tick && edge_cnt == smsp_pkg::LAST_EDGE)
      |=> state == smsp_pkg::ST_IDLE && serial_config_flags[smsp_pkg::CF_TRF];
  endproperty
  a_len: assert property (p_len) else $error("transfer did not end after eight clocks"); // [RL18]

  // Collision flagged
  property p_coll;
    (wr_data && busy) |=> serial_config_flags[smsp_pkg::CF_WRITE_COLLISION_FLAG] && irq_status[smsp_pkg::IRQ_COLL];
  endproperty
  a_coll: assert property (p_coll) else $error("collision not flagged"); // [RL16]

  // Unimplemented bit stays zero
  property p_unimpl;
    !serial_mode_control[smsp_pkg::MC_UNIMPL];
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set"); // [RL9]

  // Slave never drives the clock
  property p_slave_clk;
    (state == smsp_pkg::ST_SLAVE) |=> pins.sck_oe_n;
  endproperty
  a_slave_clk: assert property (p_slave_clk) else $error("slave drives clock"); // [RL4]

  // Select pin floats when disabled by its bit
  property p_select_pin_enable;
    !serial_config_flags[smsp_pkg::CF_SELECT_PIN_ENABLE] |=> pins.ss_oe_n;
  endproperty
  a_select_pin_enable: assert property (p_select_pin_enable) else $error("select pin driven"); // [RL6]

  // Clock rests at its idle level outside transfers
  property p_idle_lvl;
    (state == smsp_pkg::ST_IDLE) ##1 (state == smsp_pkg::ST_IDLE) |-> pins.sck == $past(idle_lvl);
  endproperty
  a_idle_lvl: assert property (p_idle_lvl) else $error("clock not at idle level"); // [RL13]

endmodule // smsp_spi

// File: shared/smsp_pkg.sv
// Summary of operation
// (RL1) Mode 000/001/010: master, system clock divided
// (RL2) Mode 011 subsidiary clock, 100 timer/2
// (RL3) 101 slave, 110 bus slave (code keeps 110 idle, no bus slave), resets 111
// (RL4) Slave shifts only on external clock edges
// (RL5) Master alone starts transfers, drives clock
// (RL6) Select-pin enable: select line, else floating
// (RL7) Full duplex: one out, one in
// (RL8) One eight-bit shift data register
// (RL9) Mode control bit 4 reads zero
// (RL10) Extra slaves need general purpose selects
// (RL11) Shift order selectable, LSB or MSB
// (RL12) Capture edge selectable, rising or falling
// (RL13) Polarity 1 idles low, 0 high
// (RL14) Order bit 1 MSB first, 0 LSB
// (RL15) Done flag set by hardware, software clears
// (RL16) Write during transfer discarded, collision flagged
// (RL17) Disabled: idle, clock and data undriven
// (RL18) Master write while idle: eight clocks
package smsp_pkg;
  localparam int unsigned AW = 8;
  // Register byte addresses
  localparam logic [7:0] OFF_MODE     = 8'h00;
  localparam logic [7:0] OFF_CFG      = 8'h04;
  localparam logic [7:0] OFF_DATA     = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h14;
  // Mode control fields
  localparam int unsigned MC_MODE_LSB = 5;
  localparam int unsigned MC_UNIMPL   = 4;
  localparam int unsigned MC_EN       = 1;
  localparam logic [7:0]  MC_RST      = 8'he0;
  localparam logic [7:0]  MC_WMASK    = 8'hef;
  // Config flag fields
  localparam int unsigned CF_POL   = 5;
  localparam int unsigned CF_EDGE  = 4;
  localparam int unsigned CF_ORDER = 3;
  localparam int unsigned CF_SELECT_PIN_ENABLE  = 2;
  localparam int unsigned CF_WRITE_COLLISION_FLAG  = 1;
  localparam int unsigned CF_TRF   = 0;
  localparam logic [7:0]  CF_RST   = 8'h00;
  localparam logic [7:0]  DATA_RST = 8'h00;
  // Interrupt bits
  localparam int unsigned IRQ_W    = 2;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_COLL = 1;
  // Sixteen clock edges per byte
  localparam logic [3:0]  LAST_EDGE = 4'hf;
  typedef enum logic [2:0] {
    MODE_DIV4  = 3'b000,
    MODE_DIV16 = 3'b001,
    MODE_DIVX  = 3'b010,
    MODE_SUB   = 3'b011,
    MODE_TMR   = 3'b100,
    MODE_SLAVE = 3'b101,
    MODE_BUS   = 3'b110,
    MODE_NONE  = 3'b111
  } smsp_mode_e;
  typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} smsp_state_e;
  typedef struct packed {
    logic sck;
    logic sck_oe_n;
    logic sdo;
    logic sdo_oe_n;
    logic ss_n;
    logic ss_oe_n;
  } smsp_pins_s;
endpackage

// File: tb/smsp_slave_model.sv
`timescale 1ns/1ps
module smsp_slave_model (
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       sdo,
  input  wire logic       cap_rise,
  input  wire logic       msb,
  input  wire logic [7:0] load_byte,
  output logic            sdi,
  output logic [7:0]      rx,
  output int              caps
);
  logic [7:0] tx;
  initial
  begin
    sdi = 1'b0;
    rx = 8'h00;
    caps = 0;
  end
  // Reply byte loaded when selected by the master
  always @(negedge ss_n)
  begin
    tx = load_byte;
    caps = 0;
    sdi = msb ? load_byte[7] : load_byte[0];
  end
  // Capture on the active edge, launch the next bit on the other
  always @(sck)
  begin
    if (!ss_n && (sck === cap_rise))
    begin
      rx = msb ? {rx[6:0], sdo} : {sdo, rx[7:1]};
      caps++;
    end
    else if (!ss_n && caps > 0 && caps < 8)
      sdi = msb ? tx[7 - caps] : tx[caps];
  end
  // Released line shows the inverse of the last bit
  always @(posedge ss_n)
    sdi = ~sdi;
endmodule // smsp_slave_model

// File: tb/spi_master_slave_port_tb.sv
`timescale 1ns/1ps
module spi_master_slave_port_tb;
  typedef struct packed {
    logic [2:0] mode;
    logic [7:0] cfg;
    logic [7:0] tx;
    logic [7:0] srx;
    logic [7:0] div;
  } smsp_row_s;
  logic                 core_clk = 0;
  logic                 nrst = 0;
  logic                 psel = 0;
  logic                 penable = 0;
  logic                 pwrite = 0;
  logic [7:0]           paddr = 0;
  logic [31:0]          pwdata = 0;
  logic                 sub_clk = 0;
  logic                 tpm = 0;
  logic                 sck_in = 0;
  logic                 tb_sdi = 0;
  logic                 slv = 0;
  logic                 sel_n = 1;
  logic [7:0]           sq;
  logic [7:0]           cur_cfg = 0;
  logic [7:0]           reply = 0;
  logic [3:0]           tick = 0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 irq;
  logic                 m_sdi;
  logic [7:0]           m_rx;
  logic [7:0]           sb;
  logic [31:0]          rv;
  logic                 re;
  int                   m_caps;
  int                   cyc;
  int                   err_total = 0;
  int                   checked = 0;
  smsp_pkg::smsp_pins_s pins;
  smsp_row_s            rows [5];

  always #20 core_clk = ~core_clk;
  // Subsidiary clock and timer match sources
  always @(posedge core_clk)
  begin
    tick <= tick + 4'h1;
    tpm <= (tick[1:0] == 2'h0);
    if (tick[1:0] == 2'h3)
      sub_clk <= ~sub_clk;
  end

  smsp_spi uut (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sub_clk(sub_clk), .timer_period_match(tpm), .sck_in(sck_in), .sdi(slv ? tb_sdi : m_sdi),
    .slave_select_n_in(sel_n), .pins(pins), .irq(irq));
  smsp_slave_model model (
    .sck(pins.sck), .ss_n(pins.ss_oe_n | pins.ss_n), .sdo(pins.sdo),
    .cap_rise(cur_cfg[5] == cur_cfg[4]), .msb(cur_cfg[3]), .load_byte(reply),
    .sdi(m_sdi), .rx(m_rx), .caps(m_caps));

  task automatic results;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Compare one value
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, setup then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_total++;
      results();
    end
    @(posedge core_clk);
  endtask
  // Bounded wait for the interrupt line
  task automatic wait_irq;
    cyc = 0;
    while (irq !== 1'b1)
    begin
      @(posedge core_clk);
      cyc++;
      if (cyc > 3000)
      begin
        err_total++;
        results();
      end
    end
  endtask

  initial
  begin
    rows[0] = '{3'b000, 8'h0c, 8'ha5, 8'h3c, 8'd4};
    rows[1] = '{3'b001, 8'h34, 8'h81, 8'h7e, 8'd16};
    rows[2] = '{3'b010, 8'h1c, 8'h5a, 8'hc3, 8'd10};
    rows[3] = '{3'b011, 8'h24, 8'h0f, 8'hf0, 8'd0};
    rows[4] = '{3'b100, 8'h0c, 8'h96, 8'h69, 8'd0};
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    check("oe_n", {pins.sck_oe_n, pins.sdo_oe_n, pins.ss_oe_n}, 3'h7);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 8'(i * 4), 0);
      check("reset", rv, (i == 0) ? 32'he0 : 32'h0);
    end
    apb(1'b1, smsp_pkg::OFF_MODE, 32'hff);
    apb(1'b0, smsp_pkg::OFF_MODE, 0);
    check("mode", rv, 32'hef);
    apb(1'b1, smsp_pkg::OFF_CFG, 32'hfc);
    apb(1'b0, smsp_pkg::OFF_CFG, 0);
    check("cfg_rw", rv, 32'hfc);
    apb(1'b0, 8'h18, 0);
    check("slverr", {31'h0, re}, 32'h1);
    check("unmapped", rv, 32'h0);
    apb(1'b1, smsp_pkg::OFF_IRQ_EN, 32'h1);
    // Master transfers over every clock source
    foreach (rows[i])
    begin
      cur_cfg <= rows[i].cfg;
      reply <= rows[i].srx;
      apb(1'b1, smsp_pkg::OFF_CFG, rows[i].cfg);
      apb(1'b1, smsp_pkg::OFF_MODE, {rows[i].mode, 5'h02});
      apb(1'b1, smsp_pkg::OFF_DATA, rows[i].tx);
      @(posedge core_clk);
      check("drive", {pins.sck_oe_n, pins.ss_oe_n, pins.ss_n}, 3'h0);
      wait_irq();
      if (rows[i].div != 0)
        check("cycles", (cyc >= 8 * rows[i].div - 4) && (cyc <= 8 * rows[i].div + 8), 1);
      check("edges", m_caps, 8);
      check("slave_rx", m_rx, rows[i].tx);
      check("sck_idle", pins.sck, {31'h0, ~rows[i].cfg[5]});
      apb(1'b0, smsp_pkg::OFF_DATA, 0);
      check("master_rx", rv, rows[i].srx);
      apb(1'b0, smsp_pkg::OFF_CFG, 0);
      check("done", rv, rows[i].cfg | 8'h01);
      apb(1'b1, smsp_pkg::OFF_CFG, rows[i].cfg);
      apb(1'b1, smsp_pkg::OFF_IRQ_CLR, 32'h3);
      @(posedge core_clk);
      check("irq_clr", irq, 0);
    end
    // Collision while busy, masked then unmasked interrupt
    cur_cfg <= 8'h0c;
    apb(1'b1, smsp_pkg::OFF_IRQ_EN, 32'h0);
    apb(1'b1, smsp_pkg::OFF_MODE, 32'h22);
    apb(1'b1, smsp_pkg::OFF_DATA, 32'h11);
    apb(1'b1, smsp_pkg::OFF_DATA, 32'h22);
    rv = 0;
    for (int k = 0; k < 100 && rv[0] !== 1'b1; k++)
      apb(1'b0, smsp_pkg::OFF_IRQ_STAT, 0);
    if (rv[0] !== 1'b1)
    begin
      err_total++;
      results();
    end
    check("stat", rv, 32'h3);
    check("masked", irq, 0);
    check("discard", m_rx, 8'h11);
    apb(1'b0, smsp_pkg::OFF_CFG, 0);
    check("write_collision_flag", rv, 32'h0f);
    apb(1'b1, smsp_pkg::OFF_IRQ_EN, 32'h3);
    @(posedge core_clk);
    check("irq_on", irq, 1);
    apb(1'b1, smsp_pkg::OFF_IRQ_CLR, 32'h3);
    apb(1'b1, smsp_pkg::OFF_CFG, 32'h0c);
    check("irq_off", irq, 0);
    // Slave exchange clocked by the bench, selected by its pin
    slv <= 1'b1;
    sel_n <= 1'b0;
    sb = 8'hb2;
    apb(1'b1, smsp_pkg::OFF_CFG, 32'h3c);
    apb(1'b1, smsp_pkg::OFF_MODE, 32'ha2);
    @(posedge core_clk);
    check("slv_sck", pins.sck_oe_n, 1);
    check("slv_sdo_oe", pins.sdo_oe_n, 0);
    apb(1'b1, smsp_pkg::OFF_DATA, 32'h4d);
    for (int b = 7; b >= 0; b--)
    begin
      tb_sdi <= sb[b];
      repeat (3) @(posedge core_clk);
      sq[b] = pins.sdo;
      sck_in <= 1'b1;
      repeat (3) @(posedge core_clk);
      sck_in <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    check("slv_tx", sq, 8'h4d);
    apb(1'b0, smsp_pkg::OFF_DATA, 0);
    check("slv_rx", rv, 32'hb2);
    apb(1'b0, smsp_pkg::OFF_CFG, 0);
    check("slv_done", rv, 32'h3d);
    // Deselected slave ignores the clock and floats its output
    apb(1'b1, smsp_pkg::OFF_CFG, 32'h3c);
    sel_n <= 1'b1;
    repeat (16)
    begin
      repeat (3) @(posedge core_clk);
      sck_in <= ~sck_in;
    end
    repeat (3) @(posedge core_clk);
    check("desel_oe", pins.sdo_oe_n, 1);
    apb(1'b0, smsp_pkg::OFF_DATA, 0);
    check("desel_rx", rv, 32'hb2);
    apb(1'b0, smsp_pkg::OFF_CFG, 0);
    check("desel_done", rv, 32'h3c);
    // Disabled: start request leaves the lines undriven
    apb(1'b1, smsp_pkg::OFF_MODE, 32'h00);
    apb(1'b1, smsp_pkg::OFF_DATA, 32'h55);
    check("off", {pins.sck_oe_n, pins.sdo_oe_n}, 2'h3);
    results();
  end
endmodule // spi_master_slave_port_tb
